// *** design/i2c_ten_if.sv ***
// open-drain i2c wires shared by the two ends
`timescale 1ns/100ps
`default_nettype none
interface i2c_ten_if;
  logic scl_oe_n_m;
  logic sda_oe_n_m;
  logic scl_oe_n_s;
  logic sda_oe_n_s;
  // low output enable pulls the wire low; released wires float high
  wire logic scl = scl_oe_n_m & scl_oe_n_s;
  wire logic sda = sda_oe_n_m & sda_oe_n_s;
  modport device (input scl, input sda, output scl_oe_n_s, output sda_oe_n_s);
  modport master (input scl, input sda, output scl_oe_n_m, output sda_oe_n_m);
endinterface
`default_nettype wire

// *** design/i2c_ten_master.sv ***
// wishbone-controlled i2c bus master that drives the ten-bit transfers
`timescale 1ns/100ps
`default_nettype none
module i2c_ten_master (
  input wire logic sys_clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic clk_en, // freezes all state when low
  i2c_ten_if.master bus, // i2c wires
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write
  input wire logic [5:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte lanes
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // acknowledge
  output logic irq // unmasked status level
);
  typedef enum logic [5:0] {
    M_IDLE = 6'b000001,
    M_START = 6'b000010,
    M_BIT = 6'b000100,
    M_ACK = 6'b001000,
    M_STOP = 6'b010000,
    M_WAIT = 6'b100000
  } mstate_t;
  mstate_t st_q;
  logic [7:0] tx_q;
  logic [2:0] status_q, mask_q;
  logic [15:0] cnt_q;
  logic [3:0] bit_q;
  logic [1:0] ph_q; // quarter phase within one scl period
  logic [2:0] cmd_q;
  logic scl_o_q, sda_o_q;
  logic [1:0] scl_sync_q, sda_sync_q;
  wire logic [3:0] idx = wb_adr_i[5:2];
  wire logic wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire logic wr = wb_req & wb_we_i & wb_sel_i[0];
  wire logic busy = (st_q != M_IDLE);
  wire logic tick = (cnt_q == 16'(i2c_ten_pkg::SCL_HALF_CYC / 2 - 1));
  // scl held low by the slave stretches the low phase; the count waits until the wire goes high
  wire logic stalled = scl_o_q & ~scl_sync_q[1];
  wire logic [7:0] rd_mux = (idx == i2c_ten_pkg::REG_TXDATA) ? tx_q
                          : (idx == i2c_ten_pkg::REG_STATUS) ? {5'h00, busy, status_q[1:0]}
                          : (idx == i2c_ten_pkg::REG_MASK) ? {5'h00, mask_q} : 8'h00;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      mask_q <= i2c_ten_pkg::MASK_RST[2:0];
      irq <= 1'b0;
    end else if (clk_en) begin
      scl_sync_q <= {scl_sync_q[0], bus.scl};
      sda_sync_q <= {sda_sync_q[0], bus.sda};
      wb_ack_o <= wb_req;
      if (wb_req) wb_dat_o <= {24'h000000, rd_mux};
      if (wr && idx == i2c_ten_pkg::REG_MASK) mask_q <= wb_dat_i[2:0];
      irq <= |(status_q[1:0] & mask_q[1:0]);
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= M_IDLE;
      tx_q <= 8'h00;
      status_q <= i2c_ten_pkg::STATUS_RST[2:0];
      cnt_q <= 16'h0000;
      bit_q <= 4'h0;
      ph_q <= 2'h0;
      cmd_q <= i2c_ten_pkg::CTRL_RST[2:0];
      scl_o_q <= 1'b1;
      sda_o_q <= 1'b1;
    end else if (clk_en) begin
      if (wr && idx == i2c_ten_pkg::REG_TXDATA) tx_q <= wb_dat_i[7:0];
      if (wr && idx == i2c_ten_pkg::REG_STATUS) status_q[1:0] <= status_q[1:0] & ~wb_dat_i[1:0];
      if (wr && idx == i2c_ten_pkg::REG_CTRL && !busy) cmd_q <= wb_dat_i[2:0];
      if (!stalled) cnt_q <= tick ? 16'h0000 : cnt_q + 16'h0001;
      if (tick && !stalled) begin
        ph_q <= ph_q + 2'h1;
        unique case (st_q)
          M_IDLE: begin
            ph_q <= 2'h0;
            if (cmd_q[i2c_ten_pkg::CMD_START]) st_q <= M_START;
            else if (cmd_q[i2c_ten_pkg::CMD_BYTE]) st_q <= M_BIT;
            else if (cmd_q[i2c_ten_pkg::CMD_STOP]) st_q <= M_STOP;
            bit_q <= 4'h0;
          end
          M_START: begin
            if (ph_q == 2'h0) begin sda_o_q <= 1'b1; scl_o_q <= 1'b1; end
            if (ph_q == 2'h2) sda_o_q <= 1'b0;
            if (ph_q == 2'h3) begin scl_o_q <= 1'b0; cmd_q[i2c_ten_pkg::CMD_START] <= 1'b0; st_q <= M_WAIT; end
          end
          M_BIT: begin
            if (ph_q == 2'h0) sda_o_q <= (bit_q == 4'h8) ? 1'b1 : tx_q[3'(7 - bit_q)];
            if (ph_q == 2'h1) scl_o_q <= 1'b1;
            if (ph_q == 2'h2 && bit_q == 4'h8) status_q[i2c_ten_pkg::ST_NACK] <= sda_sync_q[1] | status_q[1];
            if (ph_q == 2'h3) begin
              scl_o_q <= 1'b0;
              bit_q <= bit_q + 4'h1;
              if (bit_q == 4'h8) begin cmd_q[i2c_ten_pkg::CMD_BYTE] <= 1'b0; st_q <= M_WAIT; end
            end
          end
          M_STOP: begin
            if (ph_q == 2'h0) sda_o_q <= 1'b0;
            if (ph_q == 2'h1) scl_o_q <= 1'b1;
            if (ph_q == 2'h3) begin sda_o_q <= 1'b1; cmd_q <= 3'h0; st_q <= M_WAIT; end
          end
          M_WAIT: begin
            status_q[i2c_ten_pkg::ST_DONE] <= 1'b1;
            st_q <= M_IDLE;
          end
          default: st_q <= M_IDLE;
        endcase
      end
    end
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus.scl_oe_n_m <= 1'b1;
      bus.sda_oe_n_m <= 1'b1;
    end else if (clk_en) begin
      bus.scl_oe_n_m <= scl_o_q;
      bus.sda_oe_n_m <= sda_o_q;
    end
  end
endmodule
`default_nettype wire

// *** design/i2c_ten_pkg.sv ***
// shared constants for the ten-bit i2c slave receiver and its bus master
package i2c_ten_pkg;
  localparam logic [4:0] TEN_BIT_PREFIX = 5'h1E; // 11110 prefix of the high address byte
  localparam int unsigned SYS_CLK_MHZ = 100;
  localparam int unsigned SCL_HALF_NS = 2500;
  localparam int unsigned SCL_HALF_CYC = SCL_HALF_NS * SYS_CLK_MHZ / 1000;
  localparam logic [9:0] OWN_ADDR_RST = 10'h000;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;
  // master register offsets (word addresses, byte address = 4 * index)
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_TARGET = 4'h1;
  localparam logic [3:0] REG_TXDATA = 4'h2;
  localparam logic [3:0] REG_STATUS = 4'h3;
  localparam logic [3:0] REG_MASK = 4'h4;
  // ctrl command bits
  localparam int CMD_START = 0;
  localparam int CMD_BYTE = 1;
  localparam int CMD_STOP = 2;
  // master status bits
  localparam int ST_DONE = 0;
  localparam int ST_NACK = 1;
  localparam int ST_BUSY = 2;
  // device status bits
  localparam int DS_START = 0;
  localparam int DS_UA = 1;
  localparam int DS_BF = 2;
  localparam int DS_STOP = 3;
endpackage

// *** design/i2c_ten_slave.sv ***
// ten-bit address i2c slave receiver with software flag handshake
//
// Decided for this implementation: the Wishbone slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - start sets start flag, optional interrupt
// - matching high byte sets update-address flag
// - high match is acked then interrupt set
// - software clears interrupt flag per event
// - buffer read clears buffer-full flag
// - hold scl after high match until reload
// - software writes address only after ack
// - low match sets update flag, acks, interrupts
// - low mismatch still sets interrupt and update
// - low mismatch leaves full flag, release bit
// - software restores high address after match
// - data ack on ninth pulse then interrupt
// - stretch enable clears release bit per byte
// - software sets release bit after reading
// - byte sequence repeats until stop
// - address/data hold stretch as seven-bit modes
module i2c_ten_slave (
  input wire logic sys_clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic clk_en, // freezes all state when low
  i2c_ten_if.device bus, // i2c wires
  input wire logic [7:0] addr_wdata, // address-match register write value
  input wire logic addr_we, // write address-match register
  input wire logic buf_re, // read receive buffer
  input wire logic rel_set, // set clock-release bit
  input wire logic int_clr, // clear serial interrupt flag
  input wire logic ua_clr, // clear update-address flag
  input wire logic [3:0] stat_clr, // write-one-to-clear start, update and stop bits; bit 2 has no effect, full clears on buffer read
  input wire logic [3:0] mask_wdata, // interrupt mask value
  input wire logic mask_we, // write mask
  input wire logic start_int_en, // interrupt on start detection
  input wire logic clock_stretch_enable, // stretch after data bytes
  input wire logic address_hold_enable, // stretch after address ack
  input wire logic data_hold_enable, // stretch after data ack
  output logic [7:0] serial_receive_buffer, // last acknowledged byte
  output logic [7:0] address_match_register, // current match value
  output logic [3:0] serial_status_register, // stop, full, update, start
  output logic serial_interrupt_flag, // byte or start event
  output logic clock_release_bit, // scl released when high
  output logic irq // event flag or unmasked status level
);
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_RECV = 5'b00010,
    S_ACK = 5'b00100,
    S_HOLD = 5'b01000,
    S_SKIP = 5'b10000
  } state_t;
  state_t state_q, state_d;
  logic [1:0] scl_sync_q, sda_sync_q;
  logic scl_q, sda_q;
  logic [7:0] shift_q;
  logic [3:0] bitcnt_q;
  logic [1:0] phase_q; // 0 high byte, 1 low byte, 2 data
  logic [3:0] mask_q;
  logic sda_drv_q, scl_hold_q, hold_addr_q;
  // the first stage feeds only the second
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else if (clk_en) begin
      scl_sync_q <= {scl_sync_q[0], bus.scl};
      sda_sync_q <= {sda_sync_q[0], bus.sda};
      scl_q <= scl_sync_q[1];
      sda_q <= sda_sync_q[1];
    end
  end
  wire logic scl_s = scl_sync_q[1];
  wire logic sda_s = sda_sync_q[1];
  wire logic scl_rise = scl_s & ~scl_q;
  wire logic scl_fall = ~scl_s & scl_q;
  wire logic start_det = scl_s & scl_q & sda_q & ~sda_s;
  wire logic stop_det = scl_s & scl_q & ~sda_q & sda_s;
  wire logic [7:0] rx_byte = shift_q;
  wire logic byte_done = (state_q == S_RECV) && scl_fall && (bitcnt_q == 4'h8);
  // only a write request is taken: this end never transmits
  wire logic high_match = (rx_byte == {i2c_ten_pkg::TEN_BIT_PREFIX, address_match_register[2:1], 1'b0});
  wire logic low_match = (rx_byte == address_match_register);
  wire logic is_match = (phase_q == 2'h0) ? high_match : (phase_q == 2'h1) ? low_match : 1'b1;
  wire logic ack_end = (state_q == S_ACK) && scl_fall;
  wire logic stretch_now = (phase_q == 2'h2) ? (clock_stretch_enable | data_hold_enable)
                           : address_hold_enable;
  // a high byte meant for another device leaves the update flag alone
  wire logic ua_set = byte_done && ((phase_q == 2'h0) ? high_match : (phase_q == 2'h1));
  wire logic int_set = (start_det & start_int_en) | ack_end | (byte_done & (phase_q == 2'h1) & ~low_match);
  wire logic bf_set = byte_done & is_match;
  wire logic rel_clr = ack_end && (stretch_now || phase_q == 2'h0);
  wire logic rel_rise = rel_set || (hold_addr_q && addr_we);
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      S_IDLE: state_d = S_IDLE;
      S_RECV: if (byte_done) state_d = is_match ? S_ACK : S_SKIP;
      S_ACK: if (scl_fall) state_d = S_HOLD;
      S_HOLD: if (!scl_hold_q) state_d = S_RECV;
      S_SKIP: state_d = S_SKIP;
      default: state_d = S_IDLE; // an upset one-hot code falls back to idle
    endcase
    if (start_det) state_d = S_RECV;
    else if (stop_det) state_d = S_IDLE;
  end
  // bit receiver: data is taken on the synchronised rising edge of scl
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= S_IDLE;
      shift_q <= 8'h00;
      bitcnt_q <= 4'h0;
    end else if (clk_en) begin
      state_q <= state_d;
      if (start_det || byte_done) begin
        bitcnt_q <= 4'h0;
      end else if (state_q == S_RECV && scl_rise) begin
        shift_q <= {shift_q[6:0], sda_s};
        bitcnt_q <= bitcnt_q + 4'h1;
      end
    end
  end
  // acknowledge drive and clock-hold control
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= 2'h0;
      sda_drv_q <= 1'b0;
      scl_hold_q <= 1'b0;
      hold_addr_q <= 1'b0;
    end else if (clk_en) begin
      if (start_det) begin
        phase_q <= 2'h0;
        sda_drv_q <= 1'b0;
        scl_hold_q <= 1'b0;
        hold_addr_q <= 1'b0;
      end else begin
        if (byte_done) begin
          sda_drv_q <= is_match;
        end
        if (ack_end) begin
          sda_drv_q <= 1'b0;
          if (phase_q == 2'h0) begin
            scl_hold_q <= 1'b1;
            hold_addr_q <= 1'b1;
          end else begin
            scl_hold_q <= stretch_now;
          end
          if (phase_q != 2'h2) phase_q <= phase_q + 2'h1;
        end
        if (hold_addr_q && addr_we) begin
          scl_hold_q <= 1'b0;
          hold_addr_q <= 1'b0;
        end else if (!hold_addr_q && clock_release_bit == 1'b0 && rel_set) begin
          scl_hold_q <= 1'b0;
        end
      end
    end
  end
  // software-visible registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      address_match_register <= i2c_ten_pkg::OWN_ADDR_RST[7:0];
      serial_receive_buffer <= 8'h00;
      mask_q <= i2c_ten_pkg::MASK_RST[3:0];
    end else if (clk_en) begin
      if (addr_we) address_match_register <= addr_wdata;
      if (bf_set) serial_receive_buffer <= rx_byte;
      if (mask_we) mask_q <= mask_wdata;
    end
  end
  // release bit: cleared when hardware starts a hold, so software setting it releases any hold except the high-byte one, which the address write ends
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      clock_release_bit <= 1'b1;
    end else if (clk_en) begin
      if (rel_clr) clock_release_bit <= 1'b0;
      else if (rel_rise) clock_release_bit <= 1'b1;
    end
  end
  // status flags and interrupt; irq lags the flags by one cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      serial_status_register <= i2c_ten_pkg::STATUS_RST[3:0];
      serial_interrupt_flag <= 1'b0;
      irq <= 1'b0;
    end else if (clk_en) begin
      // set beats a clear arriving in the same cycle
      serial_status_register[i2c_ten_pkg::DS_START] <=
        start_det | (serial_status_register[i2c_ten_pkg::DS_START] & ~stat_clr[i2c_ten_pkg::DS_START]);
      serial_status_register[i2c_ten_pkg::DS_UA] <=
        ua_set | (serial_status_register[i2c_ten_pkg::DS_UA] & ~ua_clr & ~stat_clr[i2c_ten_pkg::DS_UA]);
      serial_status_register[i2c_ten_pkg::DS_BF] <=
        bf_set | (serial_status_register[i2c_ten_pkg::DS_BF] & ~buf_re);
      serial_status_register[i2c_ten_pkg::DS_STOP] <=
        stop_det | (serial_status_register[i2c_ten_pkg::DS_STOP] & ~stat_clr[i2c_ten_pkg::DS_STOP]);
      serial_interrupt_flag <= int_set | (serial_interrupt_flag & ~int_clr);
      irq <= serial_interrupt_flag | |(serial_status_register & mask_q);
    end
  end
  // wire drivers: low enable pulls low
  // the hold waits for scl low so a high phase is never cut short
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus.sda_oe_n_s <= 1'b1;
      bus.scl_oe_n_s <= 1'b1;
    end else if (clk_en) begin
      bus.sda_oe_n_s <= ~sda_drv_q;
      bus.scl_oe_n_s <= ~(scl_hold_q & ~scl_s);
    end
  end
endmodule
`default_nettype wire

// *** verif/i2c_ten_asserts.sv ***
// concurrent checks on the ten-bit i2c link wires and the receiver flags
`timescale 1ns/100ps
`default_nettype none
module i2c_ten_asserts (
  input wire logic sys_clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic scl, // clock wire
  input wire logic sda, // data wire
  input wire logic scl_oe_n_s, // slave clock pull
  input wire logic sda_oe_n_s, // slave data pull
  input wire logic start_int_en, // interrupt on start
  input wire logic buf_re, // buffer read pulse
  input wire logic rel_set, // release bit set pulse
  input wire logic addr_we, // address write pulse
  input wire logic int_clr, // flag clear pulse
  input wire logic [3:0] serial_status_register, // stop, full, update, start
  input wire logic serial_interrupt_flag, // event flag
  input wire logic clock_release_bit, // scl released when high
  input wire logic irq // slave interrupt level
);
  logic [2:0] since_rel_q;
  logic [2:0] since_rel_d;
  // cycles since software last let the clock go, saturating so it never wraps into a false pass
  assign since_rel_d = (addr_we | rel_set) ? 3'h0 : ((since_rel_q == 3'h7) ? 3'h7 : since_rel_q + 3'h1);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) since_rel_q <= 3'h7;
    else since_rel_q <= since_rel_d;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  AST_START_FLAG: assert property ($fell(sda) && scl |-> ##[1:8] serial_status_register[0])
    else $error("start condition not flagged");
  AST_START_INT: assert property (start_int_en && $fell(sda) && scl |-> ##[1:8] serial_interrupt_flag)
    else $error("start interrupt missing");
  AST_BUF_CLR: assert property (buf_re |=> !serial_status_register[2])
    else $error("buffer read left full flag set");
  AST_INT_CLR: assert property (int_clr |=> !serial_interrupt_flag)
    else $error("interrupt flag not cleared");
  AST_SDA_STEADY: assert property ($changed(sda_oe_n_s) |-> !scl && !$past(scl))
    else $error("slave moved data while clock high");
  AST_REL_SET: assert property (rel_set |=> clock_release_bit)
    else $error("release bit not set");
  AST_STRETCH: assert property ($fell(clock_release_bit) |-> ##[0:600] !scl_oe_n_s)
    else $error("cleared release bit did not hold clock");
  AST_SW_RELEASE: assert property ($rose(scl_oe_n_s) |-> since_rel_q < 3'h6)
    else $error("clock released without software");
  AST_IRQ: assert property ($past(serial_interrupt_flag) |-> irq)
    else $error("flag did not raise irq");
endmodule
`default_nettype wire

// *** verif/tb_top.sv ***
// self-checking bench joining the ten-bit i2c master and slave
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam logic [7:0] HI_BYTE = {i2c_ten_pkg::TEN_BIT_PREFIX, 2'b10, 1'b0}; // own address 10'h2A5
  localparam logic [7:0] LO_BYTE = 8'hA5;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [5:0] wb_adr = 6'h00;
  logic [3:0] wb_sel = 4'h1;
  logic [31:0] wb_wdat = 32'h0;
  logic [31:0] wb_rdat;
  logic [31:0] rd;
  logic wb_ack, m_irq, s_irq, s_flag, s_rel;
  logic [7:0] rx_buf, amr;
  logic [3:0] s_stat;
  logic [7:0] addr_wdata = 8'h00;
  logic [4:0] sw_pulse = 5'h00; // addr_we, buf_re, rel_set, int_clr, ua_clr
  logic [3:0] stat_clr = 4'h0;
  logic [3:0] mask_wdata = 4'h0;
  logic mask_we = 1'b0;
  logic start_int_en = 1'b1;
  logic stretch_en = 1'b0;
  logic addr_hold = 1'b0;
  logic data_hold = 1'b0;
  logic [7:0] wire_sh = 8'h00;
  logic wire_ack = 1'b1;
  int bit_cnt = 0;
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;
  i2c_ten_if bus();
  i2c_ten_slave i_i2c_ten_slave (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(1'b1), .bus(bus.device),
    .addr_wdata(addr_wdata), .addr_we(sw_pulse[4]), .buf_re(sw_pulse[3]), .rel_set(sw_pulse[2]),
    .int_clr(sw_pulse[1]), .ua_clr(sw_pulse[0]), .stat_clr(stat_clr), .mask_wdata(mask_wdata), .mask_we(mask_we),
    .start_int_en(start_int_en), .clock_stretch_enable(stretch_en), .address_hold_enable(addr_hold),
    .data_hold_enable(data_hold), .serial_receive_buffer(rx_buf), .address_match_register(amr),
    .serial_status_register(s_stat), .serial_interrupt_flag(s_flag), .clock_release_bit(s_rel), .irq(s_irq));
  i2c_ten_master i_i2c_ten_master (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(1'b1), .bus(bus.master),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel),
    .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .irq(m_irq));
  i2c_ten_asserts i_i2c_ten_asserts (.sys_clk(sys_clk), .rst_n(rst_n), .scl(bus.scl), .sda(bus.sda),
    .scl_oe_n_s(bus.scl_oe_n_s), .sda_oe_n_s(bus.sda_oe_n_s), .start_int_en(start_int_en), .buf_re(sw_pulse[3]),
    .rel_set(sw_pulse[2]), .addr_we(sw_pulse[4]), .int_clr(sw_pulse[1]), .serial_status_register(s_stat),
    .serial_interrupt_flag(s_flag), .clock_release_bit(s_rel), .irq(s_irq));
  always #5 sys_clk = ~sys_clk;
  // wire monitor: a start restarts the bit count, the ninth bit of each byte is the acknowledge
  always @(negedge bus.sda) if (bus.scl === 1'b1) bit_cnt = 0;
  always @(posedge bus.scl) begin
    if (bit_cnt == 8) wire_ack = bus.sda;
    else wire_sh = {wire_sh[6:0], bus.sda};
    bit_cnt = (bit_cnt == 8) ? 0 : bit_cnt + 1;
  end
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      mismatches = mismatches + 1;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wb(input logic we, input logic [3:0] idx, input logic [31:0] wd, output logic [31:0] rdat);
    @(posedge sys_clk);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= {idx, 2'b00};
    wb_wdat <= wd;
    do @(posedge sys_clk); while (wb_ack !== 1'b1);
    rdat = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask
  task automatic cmd(input int bit_no, input logic wait_end);
    wb(1'b1, i2c_ten_pkg::REG_STATUS, 32'h3, rd);
    wb(1'b1, i2c_ten_pkg::REG_CTRL, 32'h1 << bit_no, rd);
    if (wait_end) wait_done();
  endtask
  task automatic wait_done();
    do wb(1'b0, i2c_ten_pkg::REG_STATUS, 32'h0, rd); while (rd[i2c_ten_pkg::ST_DONE] !== 1'b1);
  endtask
  task automatic send(input logic [7:0] b);
    wb(1'b1, i2c_ten_pkg::REG_TXDATA, {24'h0, b}, rd);
    cmd(i2c_ten_pkg::CMD_BYTE, 1'b0);
  endtask
  task automatic pulse(input logic [4:0] p, input logic [3:0] sc);
    @(posedge sys_clk);
    sw_pulse <= p;
    stat_clr <= sc;
    @(posedge sys_clk);
    sw_pulse <= 5'h00;
    stat_clr <= 4'h0;
  endtask
  task automatic load_addr(input logic [7:0] b);
    addr_wdata <= b;
    pulse(5'h10, 4'h0);
  endtask
  task automatic wait_flag();
    wait (s_flag === 1'b1);
    @(posedge sys_clk);
  endtask
  // software service of one byte event: clear the flag, read the buffer, clear the update flag
  task automatic service(input logic [7:0] exp_buf, input logic [1:0] exp_fu);
    check("event flag", s_flag, 1'b1);
    check("receive buffer", rx_buf, exp_buf);
    check("full and update", s_stat[2:1], exp_fu);
    pulse(5'h0B, 4'h0);
    repeat (2) @(posedge sys_clk);
    check("flags cleared", {s_flag, s_stat[2:1]}, 3'b000);
  endtask
  task automatic scen_match();
    logic [7:0] d;
    load_addr(HI_BYTE);
    cmd(i2c_ten_pkg::CMD_START, 1'b1);
    check("start flag and event", {s_flag, s_stat[0]}, 2'b11);
    pulse(5'h02, 4'h1);
    send(HI_BYTE);
    wait_flag();
    check("high byte on wire", wire_sh, HI_BYTE);
    check("high ack", wire_ack, 1'b0);
    service(HI_BYTE, 2'b11);
    repeat (600) @(posedge sys_clk);
    check("clock held", bus.scl_oe_n_s, 1'b0);
    load_addr(LO_BYTE);
    wait_done();
    check("address register", amr, LO_BYTE);
    addr_hold <= 1'b1;
    send(LO_BYTE);
    wait_flag();
    check("low ack", wire_ack, 1'b0);
    service(LO_BYTE, 2'b11);
    check("address hold", {s_rel, bus.scl_oe_n_s}, 2'b00);
    load_addr(HI_BYTE);
    pulse(5'h04, 4'h0);
    addr_hold <= 1'b0;
    wait_done();
    for (int i = 0; i < 2; i++) begin
      d = (i == 0) ? 8'h3C : 8'hC3;
      stretch_en <= (i == 0);
      data_hold <= (i == 1);
      send(d);
      wait_flag();
      check("data ack", wire_ack, 1'b0);
      check("release bit", s_rel, 1'b0);
      service(d, 2'b10);
      repeat (600) @(posedge sys_clk);
      check("data clock held", bus.scl_oe_n_s, 1'b0);
      pulse(5'h04, 4'h0);
      wait_done();
    end
    data_hold <= 1'b0;
    cmd(i2c_ten_pkg::CMD_STOP, 1'b1);
    check("stop flag", s_stat[3], 1'b1);
  endtask
  task automatic scen_mismatch();
    pulse(5'h02, 4'hF);
    cmd(i2c_ten_pkg::CMD_START, 1'b1);
    pulse(5'h02, 4'h0);
    send(HI_BYTE);
    wait_flag();
    service(HI_BYTE, 2'b11);
    load_addr(LO_BYTE);
    wait_done();
    send(8'hA6);
    wait_flag();
    check("release untouched", s_rel, 1'b1);
    service(HI_BYTE, 2'b01);
    wait_done();
    check("low mismatch nack", {rd[i2c_ten_pkg::ST_NACK], wire_ack}, 2'b11);
    load_addr(HI_BYTE);
    cmd(i2c_ten_pkg::CMD_STOP, 1'b1);
  endtask
  task automatic scen_irq();
    wb(1'b1, i2c_ten_pkg::REG_MASK, 32'h1, rd);
    wb(1'b0, i2c_ten_pkg::REG_MASK, 32'h0, rd);
    check("mask readback", rd, 32'h1);
    check("master irq", m_irq, 1'b1);
    wb(1'b1, i2c_ten_pkg::REG_STATUS, 32'h1, rd);
    wb(1'b0, 4'hF, 32'h0, rd);
    check("unmapped read", rd, 32'h0);
    check("master irq cleared", m_irq, 1'b0);
    mask_wdata <= 4'h8;
    mask_we <= 1'b1;
    @(posedge sys_clk);
    mask_we <= 1'b0;
    repeat (3) @(posedge sys_clk);
    check("slave irq", s_irq, 1'b1);
    pulse(5'h00, 4'h8);
    repeat (2) @(posedge sys_clk);
    check("slave irq cleared", s_irq, 1'b0);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ceiling well above six bytes of traffic plus the stretches
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      mismatches = mismatches + 1;
      final_report();
    end
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    check("reset state", {s_flag, s_stat, s_rel, amr, bus.scl, bus.sda, m_irq}, {5'h00, 1'b1, 8'h00, 3'b110});
    scen_match();
    scen_mismatch();
    scen_irq();
    final_report();
  end
endmodule
`default_nettype wire
